// *** ibc_pkg.sv ***
// Constants for the interrupt, bias and channel configuration register bank
// Assumes a host-side control port that gives byte reads and writes
// What this block does
// RQ1 - Mask bit 7 masks clock error source when one; resets to one
// RQ2 - Mask bit 6 masks lock source when one; resets to one
// RQ3 - Mask register resets to all ones; low six bits read-write
// RQ4 - Latch bit 7 reads one after a clock error; read-only, self-clearing
// RQ5 - Latch bit 6 reads one after a lock event; read-only, self-clearing
// RQ6 - Latch register read-only, resets zero, bits 5-0 read zero
// RQ7 - Bias field bits 6-4: code 0 reference, code 1 reference times 1.096
// RQ8 - Bias code 6 selects analog supply; codes 2-5 reserved for host
// RQ9 - Full-scale bits 1-0: 2.75, 2.5, 1.375 V; code 3 reserved
// RQ10 - Bias register resets zero; bits 7 and 3-2 read zero
// RQ11 - Channel one config resets zero with documented field layout
// RQ12 - In event mode 0, interrupt asserts on any unmasked latched flag
// RQ13 - Readback filter set reports only unmasked flags; clear reports all
// RQ14 - Reading latch register clears flags unless event still present
// RQ15 - Flags latch regardless of mask; mask gates output, and readback when filter set
package ibc_pkg;
	localparam logic [7:0] ADDR_MASK = 8'h33;
	localparam logic [7:0] ADDR_LATCH = 8'h36;
	localparam logic [7:0] ADDR_BIAS = 8'h3B;
	localparam logic [7:0] ADDR_CH1 = 8'h3C;
	localparam logic [7:0] RST_MASK = 8'hFF;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_BIAS = 8'h00;
	localparam logic [7:0] RST_CH1 = 8'h00;
	localparam int BIT_CLK_ERR = 7;
	localparam int BIT_PLL_LOCK = 6;
	localparam logic [7:0] BIAS_WMASK = 8'h73;
	localparam logic [7:0] CH1_WMASK = 8'hFD;
	localparam logic [1:0] EVT_ANY_UNMASKED = 2'h0;
	localparam int NUM_SRC = 2;
endpackage

// *** ibc_flag_if.sv ***
// Carrier between the bank and its flag latch
// Assumes one clock domain shared by both ends
`timescale 1ns/1ns
interface ibc_flag_if;
	logic [1:0] event_raw;
	logic clear_rd;
	logic [1:0] flags;
	modport bank (output event_raw, output clear_rd, input flags);
	modport latch (input event_raw, input clear_rd, output flags);
endinterface

// *** ibc_flag_latch.sv ***
// Sticky event flags, one per source, cleared by a latch read
// Assumes events are synchronous levels on mclk_i
`timescale 1ns/1ns
module ibc_flag_latch (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	ibc_flag_if.latch fl
);
	import ibc_pkg::*;
	typedef struct packed {
		logic [NUM_SRC-1:0] flags;
	} ibc_latch_s;
	ibc_latch_s st_q;
	ibc_latch_s st_d;

	always_comb begin
		st_d = st_q;
		for (int i = 0; i < NUM_SRC; i++) begin
			if (fl.clear_rd)
				st_d.flags[i] = 1'b0; // RQ14
			if (fl.event_raw[i])
				st_d.flags[i] = 1'b1; // RQ15
		end
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	assign fl.flags = st_q.flags;
endmodule

// *** irq_bias_channel_cfg_regs.sv ***
// Register bank: interrupt masks, latched flags, bias and channel one config
// Assumes a byte-wide synchronous host port and synchronous event inputs
`timescale 1ns/1ns
module irq_bias_channel_cfg_regs (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Host register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Interrupt configuration from the neighbouring register
	input wire logic [1:0] int_event_mode_i,
	input wire logic latch_readback_filter_i,
	// Event sources
	input wire logic audio_serial_port_clk_err_i,
	input wire logic pll_lock_event_i,
	// Interrupt request, active high before polarity handling
	output logic int_req_o,
	// Configuration outputs
	output logic [2:0] mic_bias_select_o,
	output logic [1:0] converter_full_scale_select_o,
	output logic channel_one_input_type_o,
	output logic [1:0] channel_one_input_source_o,
	output logic channel_one_coupling_o,
	output logic [1:0] channel_one_impedance_o,
	output logic channel_one_range_enhancer_enable_o
);
	import ibc_pkg::*;

	typedef struct packed {
		logic [7:0] interrupt_mask_bits;
		logic [7:0] bias_cfg;
		logic [7:0] ch1_cfg;
		logic [7:0] rdata;
		logic irq;
	} ibc_bank_s;

	ibc_bank_s st_q;
	ibc_bank_s st_d;
	logic [7:0] latched_view;
	logic [1:0] unmasked;
	logic [1:0] shown;

	ibc_flag_if fl ();

	ibc_flag_latch u_latch (
		.mclk_i(mclk_i),
		.rst_b_i(rst_b_i),
		.fl(fl.latch)
	);

	// ****************************************
	// Event capture and read-to-clear
	// ****************************************
	assign fl.event_raw = {audio_serial_port_clk_err_i, pll_lock_event_i};
	assign fl.clear_rd = reg_rd_i && (reg_addr_i == ADDR_LATCH); // RQ14

	// Bit 1 of the flag vector is the clock error, bit 0 the lock event
	assign unmasked = fl.flags & ~{st_q.interrupt_mask_bits[BIT_CLK_ERR],
		st_q.interrupt_mask_bits[BIT_PLL_LOCK]}; // RQ1 RQ2 RQ15
	assign shown = latch_readback_filter_i ? unmasked : fl.flags; // RQ13

	always_comb begin
		latched_view = RST_LATCH; // RQ6
		latched_view[BIT_CLK_ERR] = shown[1]; // RQ4
		latched_view[BIT_PLL_LOCK] = shown[0]; // RQ5
	end

	// ****************************************
	// Register writes, reads and interrupt
	// ****************************************
	always_comb begin
		st_d = st_q;
		if (reg_wr_i) begin
			case (reg_addr_i)
				ADDR_MASK: st_d.interrupt_mask_bits = reg_wdata_i; // RQ3
				ADDR_BIAS: st_d.bias_cfg = reg_wdata_i & BIAS_WMASK; // RQ10
				ADDR_CH1: st_d.ch1_cfg = reg_wdata_i & CH1_WMASK; // RQ11
				default: st_d = st_q;
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				ADDR_MASK: st_d.rdata = st_q.interrupt_mask_bits;
				ADDR_LATCH: st_d.rdata = latched_view; // RQ13
				ADDR_BIAS: st_d.rdata = st_q.bias_cfg;
				ADDR_CH1: st_d.rdata = st_q.ch1_cfg;
				default: st_d.rdata = 8'h00;
			endcase
		end
		// Other event modes need timers owned elsewhere; level mode here
		st_d.irq = (int_event_mode_i == EVT_ANY_UNMASKED) && (|unmasked); // RQ12
	end

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q.interrupt_mask_bits <= RST_MASK; // RQ1 RQ2 RQ3
			st_q.bias_cfg <= RST_BIAS; // RQ10
			st_q.ch1_cfg <= RST_CH1; // RQ11
			st_q.rdata <= 8'h00;
			st_q.irq <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign reg_rdata_o = st_q.rdata;
	assign int_req_o = st_q.irq;
	assign mic_bias_select_o = st_q.bias_cfg[6:4]; // RQ7 RQ8
	assign converter_full_scale_select_o = st_q.bias_cfg[1:0]; // RQ9
	assign channel_one_input_type_o = st_q.ch1_cfg[7];
	assign channel_one_input_source_o = st_q.ch1_cfg[6:5];
	assign channel_one_coupling_o = st_q.ch1_cfg[4];
	assign channel_one_impedance_o = st_q.ch1_cfg[3:2];
	assign channel_one_range_enhancer_enable_o = st_q.ch1_cfg[0];
endmodule

// *** ibc_chk_sva.sv ***
// Port checks for the register bank
// Assumes binding onto the bank top
`timescale 1ns/1ns
module ibc_chk (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// Host register port
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	// Interrupt configuration and request
	input wire logic [1:0] int_event_mode_i,
	input wire logic latch_readback_filter_i,
	input wire logic int_req_o,
	// Event sources
	input wire logic audio_serial_port_clk_err_i,
	input wire logic pll_lock_event_i,
	// Bias outputs
	input wire logic [2:0] mic_bias_select_o,
	input wire logic [1:0] converter_full_scale_select_o
);
	import ibc_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	logic [7:0] wd_q;
	wire rl = reg_rd_i && reg_addr_i == ADDR_LATCH;
	wire ne = !audio_serial_port_clk_err_i && !pll_lock_event_i;
	wire wb = reg_wr_i && reg_addr_i == ADDR_BIAS;
	always_ff @(posedge mclk_i) wd_q <= reg_wdata_i;
	a_bias_write: assert property (
		wb |=> mic_bias_select_o == wd_q[6:4])
		else $error("bias field");
	a_scale_write: assert property (
		wb |=> converter_full_scale_select_o == wd_q[1:0])
		else $error("scale");
	a_latch_rsvd: assert property (
		rl |=> reg_rdata_o[5:0] == 6'h00)
		else $error("latch low bits");
	a_bias_rsvd: assert property (
		reg_rd_i && reg_addr_i == ADDR_BIAS |=>
		!reg_rdata_o[7] && reg_rdata_o[3:2] == 2'h0)
		else $error("bias rsvd");
	a_irq_mode: assert property (
		int_req_o |-> $past(int_event_mode_i) == 2'h0)
		else $error("irq mode");
	a_err_latch: assert property (
		audio_serial_port_clk_err_i ##1 (!rl)[*2] ##1
		rl && !latch_readback_filter_i |=> reg_rdata_o[7])
		else $error("err");
	a_pll_latch: assert property (
		pll_lock_event_i ##1 (!rl)[*2] ##1
		rl && !latch_readback_filter_i |=> reg_rdata_o[6])
		else $error("pll");
	a_read_clear: assert property (
		rl && ne ##1 ne ##1
		rl && ne && !latch_readback_filter_i |=>
		reg_rdata_o[7:6] == 2'h0)
		else $error("clr");
endmodule
bind irq_bias_channel_cfg_regs ibc_chk u_chk (.*);

// *** ibc_evt_src.sv ***
// Event source model for clock error and lock monitors
// Assumes fire_i changes just after a clock edge
`timescale 1ns/1ns
module ibc_evt_src (
	// Commands
	input wire logic [1:0] fire_i,
	// Events
	output logic err_o,
	output logic lock_o
);
	assign {err_o, lock_o} = fire_i;
endmodule

// *** irq_bias_channel_cfg_regs_bench.sv ***
// Bench for the interrupt, bias and channel one register bank
// Assumes the bank, checker and event source are compiled first
`timescale 1ns/1ns
module irq_bias_channel_cfg_regs_bench;
	logic mclk_i = 1'b0, rst_b_i = 1'b0, wr = 1'b0, rd = 1'b0, flt = 1'b0;
	logic [7:0] a = 8'h00, wd = 8'h00, rdat;
	logic [1:0] md = 2'h0, fire = 2'h0, fs, src, imp;
	logic err, lock, irq, ty, cp, dre;
	logic [2:0] mb;
	int n_errors = 0, checks = 0;
	always #50 mclk_i = ~mclk_i;
	ibc_evt_src SRC (.fire_i(fire), .err_o(err), .lock_o(lock));
	irq_bias_channel_cfg_regs DUT (.mclk_i, .rst_b_i, .reg_addr_i(a),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat),
		.int_event_mode_i(md), .latch_readback_filter_i(flt),
		.audio_serial_port_clk_err_i(err), .pll_lock_event_i(lock),
		.int_req_o(irq), .mic_bias_select_o(mb),
		.converter_full_scale_select_o(fs), .channel_one_input_type_o(ty),
		.channel_one_input_source_o(src), .channel_one_coupling_o(cp),
		.channel_one_impedance_o(imp),
		.channel_one_range_enhancer_enable_o(dre));
	task ck(string n, logic [7:0] s, e);
		checks++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask
	task acc(logic [7:0] ad, d, logic w);
		@(posedge mclk_i);
		a <= ad;
		wd <= d;
		wr <= w;
		rd <= !w;
		@(posedge mclk_i);
		wr <= 1'b0;
		rd <= 1'b0;
		@(negedge mclk_i);
		if (!w) ck("rdata", rdat, d);
	endtask
	task ev(logic [1:0] v, logic q);
		@(posedge mclk_i);
		fire <= v;
		@(posedge mclk_i);
		fire <= 2'h0;
		@(posedge mclk_i);
		@(negedge mclk_i);
		ck("irq", {7'h00, irq}, {7'h00, q});
	endtask
	task test_done;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		n_errors++;
		test_done;
	end
	initial begin
		repeat (12) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		acc(8'h33, 8'hFF, 0);
		acc(8'h36, 8'h00, 0);
		acc(8'h3B, 8'h00, 0);
		acc(8'h3C, 8'h00, 0);
		acc(8'h3B, 8'hFF, 1);
		acc(8'h3B, 8'h73, 0);
		acc(8'h3B, 8'h61, 1);
		ck("bias", {1'b0, mb, 2'h0, fs}, 8'h61);
		acc(8'h3C, 8'hFF, 1);
		acc(8'h3C, 8'hFD, 0);
		ck("ch1", {ty, src, cp, imp, 1'b0, dre}, 8'hFD);
		acc(8'h00, 8'h00, 0);
		acc(8'h36, 8'hFF, 1);
		acc(8'h36, 8'h00, 0);
		ev(2'h2, 1'b0);
		acc(8'h36, 8'h80, 0);
		acc(8'h36, 8'h00, 0);
		acc(8'h33, 8'h00, 1);
		ev(2'h1, 1'b1);
		acc(8'h36, 8'h40, 0);
		ev(2'h0, 1'b0);
		@(posedge mclk_i);
		flt <= 1'b1;
		md <= 2'h2;
		ev(2'h3, 1'b0);
		acc(8'h36, 8'hC0, 0);
		acc(8'h33, 8'h80, 1);
		ev(2'h3, 1'b0);
		acc(8'h36, 8'h40, 0);
		@(posedge mclk_i);
		md <= 2'h0;
		acc(8'h33, 8'h40, 1);
		ev(2'h1, 1'b0);
		ev(2'h2, 1'b1);
		acc(8'h36, 8'h80, 0);
		ev(2'h0, 1'b0);
		test_done;
	end
endmodule
